// ---- dtcfd_pkg.sv ----
// Shared constants, types and helpers for the transport frame delineator
`default_nettype none
package dtcfd_pkg;
    ////////////////////////////////////////////////////////////////////////
    // Transport packet layout
    localparam logic [7:0]  SYNC_BYTE   = 8'h47;
    localparam logic [7:0]  STUFF_BYTE  = 8'hff;
    localparam logic [7:0]  PKT_FIRST   = 8'h00;
    localparam logic [7:0]  PKT_LAST    = 8'hbb;
    localparam logic [7:0]  HDR_B1      = 8'h01;
    localparam logic [7:0]  HDR_B2      = 8'h02;
    localparam logic [7:0]  HDR_B3      = 8'h03;
    localparam logic [7:0]  PTR_POS     = 8'h04;
    localparam logic [7:0]  START_LAST  = 8'hb8;
    localparam logic [16:0] PAYLOAD_LEN = 17'h000b8;
    localparam logic [12:0] DATA_PID    = 13'h1ffe;
    localparam logic [12:0] NULL_PID    = 13'h1fff;
    localparam logic [1:0]  AFC_PAYLOAD = 2'h1;
    localparam int          TEI_BIT     = 7;
    localparam int          PUSI_BIT    = 6;
    localparam int          PID_HI      = 4;
    localparam int          AFC_HI      = 5;
    localparam int          AFC_LO      = 4;
    localparam int          CC_HI       = 3;
    ////////////////////////////////////////////////////////////////////////
    // Alignment run lengths
    localparam logic [2:0]  LOCK_GOOD   = 3'h5;
    localparam logic [3:0]  LOSS_BAD    = 4'h9;
    ////////////////////////////////////////////////////////////////////////
    // MAC header walk
    localparam logic [7:0]  REQ_CONTROL = 8'hc4;
    localparam logic [16:0] MAC_HDR_LEN = 17'h00006;
    localparam logic [16:0] HDR_SEEN    = 17'h00004;
    localparam logic [1:0]  HIDX_KNOWN  = 2'h0;
    localparam logic [1:0]  HIDX_PARM   = 2'h1;
    localparam logic [1:0]  HIDX_LENH   = 2'h2;
    localparam logic [1:0]  HIDX_LENL   = 2'h3;
    ////////////////////////////////////////////////////////////////////////
    // Output buffer word: {abort, eof, sof, byte}
    localparam int          W_SOF       = 8;
    localparam int          W_EOF       = 9;
    localparam int          W_ABORT     = 10;
    localparam logic [1:0]  BUF_DEPTH   = 2'h2;

    typedef enum logic [1:0] {
        FS_NEED   = 2'b00,
        FS_SKIP   = 2'b01,
        FS_SEARCH = 2'b10,
        FS_FRAME  = 2'b11
    } dtcfd_fsm_e;

    // Request headers carry a service id in the length slot
    function automatic logic [16:0] frame_total(
        input logic [7:0]  ctl_byte,
        input logic [15:0] len_field
    );
        if (ctl_byte == REQ_CONTROL) begin
            return MAC_HDR_LEN;
        end
        return {1'b0, len_field} + MAC_HDR_LEN;
    endfunction : frame_total

    // Header walk: next {hidx, lenh, rem} after one frame byte
    function automatic logic [26:0] hdr_step(
        input logic [1:0]  hidx,
        input logic [7:0]  ctl,
        input logic [7:0]  lenh,
        input logic [16:0] rem,
        input logic [7:0]  b
    );
        case (hidx)
            HIDX_PARM: return {HIDX_LENH, lenh, rem};
            HIDX_LENH: return {HIDX_LENL, b, rem};
            HIDX_LENL: return {HIDX_KNOWN, lenh,
                               frame_total(ctl, {lenh, b}) - HDR_SEEN};
            default:   return {hidx, lenh, rem - 17'h00001};
        endcase
    endfunction : hdr_step
endpackage : dtcfd_pkg
`default_nettype wire

// ---- dtcfd_link_if.sv ----
// Byte-wide transport stream link between headend and delineator
`timescale 1ns/10ps
`default_nettype none
interface dtcfd_link_if;
    logic [7:0] ts_byte;
    logic [7:0] ts_chk;
    logic       ts_valid;
    logic       ts_ready;

    modport head (
        output ts_byte,
        output ts_chk,
        output ts_valid,
        input  ts_ready
    );
    modport delin (
        input  ts_byte,
        input  ts_chk,
        input  ts_valid,
        output ts_ready
    );
endinterface : dtcfd_link_if
`default_nettype wire

// ---- dtcfd_headend.sv ----
// Headend end: packs MAC frames into transport packets
`timescale 1ns/10ps
`default_nettype none
module dtcfd_headend
    import dtcfd_pkg::*;
(
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Transport link
    dtcfd_link_if.head      link,
    // Frame bytes from the MAC
    input  wire logic [7:0] u_data,
    input  wire logic       u_valid,
    output logic            u_ready,
    // Frame start marker
    output logic            tx_stamp
);
    typedef struct packed {
        logic [7:0]  pos;
        logic [7:0]  acc;
        logic [3:0]  cc;
        logic        ours;
        logic        pusi;
        logic        infr;
        logic [1:0]  hidx;
        logic [7:0]  frame_control_byte;
        logic [7:0]  lenh;
        logic [16:0] rem;
        logic        hv;
        logic [7:0]  hb;
        logic [7:0]  obyte;
        logic [7:0]  ochk;
        logic        ovalid;
        logic        uready;
        logic        stamp;
    } dtcfd_hd_s;

    dtcfd_hd_s s;
    dtcfd_hd_s n;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin : next_state
        logic [7:0]  b;
        logic        go;
        logic        use_hold;
        logic [4:0]  ph;
        logic [7:0]  pl;
        b = STUFF_BYTE;
        go = 1'b0;
        use_hold = 1'b0;
        {ph, pl} = s.ours ? DATA_PID : NULL_PID;
        n = s;
        n.stamp = 1'b0;
        if (s.ovalid && link.ts_ready) begin
            n.ovalid = 1'b0;
        end
        if (!n.ovalid) begin
            go = 1'b1;
            case (s.pos)
                PKT_FIRST: begin
                    // Idle: a null packet rather than one full of stuffing
                    n.ours = s.hv || s.infr;
                    n.pusi = n.ours && !(s.infr && s.rem >= PAYLOAD_LEN);
                    b = SYNC_BYTE;
                    n.ochk = s.acc;
                end
                HDR_B1: begin
                    b = 8'h00;
                    b[PUSI_BIT] = s.pusi;
                    b[PID_HI:0] = ph;
                end
                HDR_B2: b = pl;
                HDR_B3: begin
                    b = 8'h00;
                    b[AFC_HI:AFC_LO] = AFC_PAYLOAD;
                    if (s.ours) begin
                        b[CC_HI:0] = s.cc;
                        n.cc = s.cc + 4'h1;
                    end
                end
                default: begin
                    if (!s.ours) begin
                        b = STUFF_BYTE;
                    end else if (s.pos == PTR_POS && s.pusi) begin
                        b = s.infr ? s.rem[7:0] : 8'h00;
                    end else if (s.infr) begin
                        // Underrun stalls, since fill would corrupt the frame
                        if (s.hv) begin
                            b = s.hb;
                            use_hold = 1'b1;
                        end else begin
                            go = 1'b0;
                        end
                    end else if (s.hv && s.pos <= START_LAST) begin
                        b = s.hb;
                        use_hold = 1'b1;
                        n.infr = 1'b1;
                        n.hidx = HIDX_PARM;
                        n.frame_control_byte = s.hb;
                        n.stamp = 1'b1;
                    end else begin
                        b = STUFF_BYTE;
                    end
                end
            endcase
            if (use_hold && s.infr) begin
                {n.hidx, n.lenh, n.rem} = hdr_step(s.hidx,
                    s.frame_control_byte, s.lenh, s.rem, s.hb);
                if (s.hidx == HIDX_KNOWN && s.rem == 17'h00001) begin
                    n.infr = 1'b0;
                end
            end
            if (go) begin
                n.obyte = b;
                n.ovalid = 1'b1;
                n.acc = (s.pos == PKT_FIRST) ? SYNC_BYTE : (s.acc ^ b);
                n.pos = (s.pos == PKT_LAST) ? PKT_FIRST : s.pos + 8'h01;
            end
        end
        if (use_hold) begin
            n.hv = 1'b0;
        end
        if (u_valid && s.uready) begin
            n.hv = 1'b1;
            n.hb = u_data;
        end
        n.uready = !n.hv;
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.uready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.ts_byte  = s.obyte;
    assign link.ts_chk   = s.ochk;
    assign link.ts_valid = s.ovalid;
    assign u_ready       = s.uready;
    assign tx_stamp      = s.stamp;
endmodule : dtcfd_headend
`default_nettype wire

// ---- dtcfd_delineator.sv ----
// Receive end: packet alignment and MAC frame delineation
//
// Contract
// - Frames start anywhere, span packets, share packets; the headend starts none after packet byte 184 (START_LAST)
// - Start flag makes first payload byte pointer
// - Pointer zero: search begins next byte
// - Pointer marks first byte after previous tail
// - Skip fill bytes between frames
// - Next pointer counts tail; resume after it
// - No start flag: whole payload continues frame
// - Headend sends null packets, not fill-only
// - Multiplexing keeps MAC timing relationships
// - Mark frame start for accurate timestamping
// - Stream carries a parity checksum per packet
// - Five good checksums, 188 apart, acquire alignment
// - Nine bad checksums lose alignment, rehunt
// - Reserved fields never steer decoding
// - Every packet starts with the sync byte
// - Only the data identifier gets frame processing
// - Gaps are fill bytes, never control bytes
// - Pointer gives bytes to skip before search
`timescale 1ns/10ps
`default_nettype none
module dtcfd_delineator
    import dtcfd_pkg::*;
#(
    parameter logic [2:0] GOOD_RUN = LOCK_GOOD,
    parameter logic [3:0] BAD_RUN  = LOSS_BAD
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Transport link
    dtcfd_link_if.delin     link,
    // Frame bytes to the MAC
    output logic [7:0]      rx_data,
    output logic            rx_sof,
    output logic            rx_eof,
    output logic            rx_abort,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    // Status
    output logic            rx_locked,
    output logic            rx_stamp
);
    typedef struct packed {
        logic        phase;
        logic        lock;
        logic [2:0]  good;
        logic [3:0]  bad;
        logic [7:0]  pos;
        logic [7:0]  acc;
        logic        tei;
        logic        pusi;
        logic [4:0]  pidh;
        logic        ours;
        logic        have_cc;
        logic [3:0]  cc;
        dtcfd_fsm_e  st;
        logic [7:0]  skip;
        logic [1:0]  hidx;
        logic [7:0]  frame_control_byte;
        logic [7:0]  lenh;
        logic [16:0] rem;
        logic [10:0] e0;
        logic [10:0] e1;
        logic [1:0]  cnt;
        logic        ovalid;
        logic        ready;
        logic        stamp;
    } dtcfd_dl_s;

    dtcfd_dl_s s;
    dtcfd_dl_s n;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin : next_state
        logic [7:0]  b;
        logic        take;
        logic        push;
        logic        drop;
        logic [10:0] w;
        logic [1:0]  c;
        b = link.ts_byte;
        take = link.ts_valid && s.ready;
        push = 1'b0;
        drop = 1'b0;
        w = '0;
        c = s.cnt;
        n = s;
        n.stamp = 1'b0;
        if (take) begin
            if (!s.phase) begin
                // Hunt: the first sync byte only sets the phase
                if (b == SYNC_BYTE) begin
                    n.phase = 1'b1;
                    n.pos = HDR_B1;
                    n.acc = b;
                    n.good = '0;
                end
            end else if (s.pos == PKT_FIRST) begin
                n.acc = b;
                n.pos = HDR_B1;
                if (b == SYNC_BYTE && link.ts_chk == s.acc) begin
                    n.bad = '0;
                    if (!s.lock) begin
                        n.good = s.good + 3'h1;
                        if (n.good == GOOD_RUN) begin
                            n.lock = 1'b1;
                        end
                    end
                end else if (s.lock) begin
                    n.bad = s.bad + 4'h1;
                    if (n.bad == BAD_RUN) begin
                        n.lock = 1'b0;
                        n.phase = 1'b0;
                        n.bad = '0;
                        n.good = '0;
                        n.have_cc = 1'b0;
                        n.ours = 1'b0;
                        drop = 1'b1;
                    end
                end else begin
                    // A miss before lock restarts the run from scratch
                    n.phase = 1'b0;
                    n.good = '0;
                end
            end else begin
                n.acc = s.acc ^ b;
                n.pos = (s.pos == PKT_LAST) ? PKT_FIRST : s.pos + 8'h01;
                if (s.lock) begin
                    // Priority and scrambling bits are never looked at
                    case (s.pos)
                        HDR_B1: begin
                            n.tei = b[TEI_BIT];
                            n.pusi = b[PUSI_BIT];
                            n.pidh = b[PID_HI:0];
                        end
                        HDR_B2: begin
                            n.ours = ({s.pidh, b} == DATA_PID) && !s.tei;
                            if ({s.pidh, b} == DATA_PID && s.tei) begin
                                drop = 1'b1;
                            end
                        end
                        HDR_B3: begin
                            if (s.ours) begin
                                if (b[AFC_HI:AFC_LO] != AFC_PAYLOAD) begin
                                    n.ours = 1'b0;
                                end else begin
                                    if (s.have_cc &&
                                        b[CC_HI:0] != s.cc + 4'h1) begin
                                        drop = 1'b1;
                                    end
                                    n.cc = b[CC_HI:0];
                                    n.have_cc = 1'b1;
                                end
                            end
                        end
                        default: begin
                            if (!s.ours) begin
                                n.st = s.st;
                            end else if (s.pos == PTR_POS && s.pusi) begin
                                // A tail that agrees with the pointer runs on
                                if (!(s.st == FS_FRAME &&
                                      s.hidx == HIDX_KNOWN &&
                                      s.rem == {9'h000, b})) begin
                                    if (s.st == FS_FRAME) begin
                                        push = 1'b1;
                                        w[W_ABORT] = 1'b1;
                                    end
                                    n.skip = b;
                                    n.st = (b == 8'h00) ? FS_SEARCH
                                                        : FS_SKIP;
                                end
                            end else begin
                                // Payload without a pointer continues as is
                                case (s.st)
                                    FS_SKIP: begin
                                        n.skip = s.skip - 8'h01;
                                        if (s.skip == 8'h01) begin
                                            n.st = FS_SEARCH;
                                        end
                                    end
                                    FS_SEARCH: begin
                                        if (b != STUFF_BYTE) begin
                                            push = 1'b1;
                                            w[7:0] = b;
                                            w[W_SOF] = 1'b1;
                                            n.stamp = 1'b1;
                                            n.st = FS_FRAME;
                                            n.hidx = HIDX_PARM;
                                            n.frame_control_byte = b;
                                        end
                                    end
                                    FS_FRAME: begin
                                        push = 1'b1;
                                        w[7:0] = b;
                                        {n.hidx, n.lenh, n.rem} = hdr_step(
                                            s.hidx, s.frame_control_byte,
                                            s.lenh, s.rem, b);
                                        if (s.hidx == HIDX_KNOWN &&
                                            s.rem == 17'h00001) begin
                                            w[W_EOF] = 1'b1;
                                            n.st = FS_SEARCH;
                                        end
                                    end
                                    default: n.st = FS_NEED;
                                endcase
                            end
                        end
                    endcase
                end
            end
        end
        if (drop) begin
            if (s.st == FS_FRAME) begin
                push = 1'b1;
                w = '0;
                w[W_ABORT] = 1'b1;
            end
            n.st = FS_NEED;
        end
        ////////////////////////////////////////////////////////////////////
        // Two-entry buffer; head always in e0 so outputs leave a flop
        if (s.ovalid && rx_ready) begin
            n.e0 = s.e1;
            c = c - 2'h1;
        end
        if (push) begin
            if (c == 2'h0) begin
                n.e0 = w;
            end else begin
                n.e1 = w;
            end
            c = c + 2'h1;
        end
        n.cnt = c;
        n.ovalid = (c != 2'h0);
        n.ready = (c != BUF_DEPTH);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
            s.ready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign link.ts_ready = s.ready;
    assign rx_data       = s.e0[7:0];
    assign rx_sof        = s.e0[W_SOF];
    assign rx_eof        = s.e0[W_EOF];
    assign rx_abort      = s.e0[W_ABORT];
    assign rx_valid      = s.ovalid;
    assign rx_locked     = s.lock;
    assign rx_stamp      = s.stamp;
endmodule : dtcfd_delineator
`default_nettype wire

// ---- dtcfd_link_asserts.sv ----
// Checker for the transport link between headend and delineator
`timescale 1ns/10ps
`default_nettype none
module dtcfd_link_asserts
    import dtcfd_pkg::*;
(
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // Transport link
    input wire logic [7:0] ts_byte,
    input wire logic [7:0] ts_chk,
    input wire logic       ts_valid,
    input wire logic       ts_ready
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] pos;
    logic [7:0] acc;
    logic [7:0] sum;
    logic       pusi;
    logic       nul;
    // Counts taken bytes only, so a stall cannot skew the position
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pos  <= PKT_FIRST;
            acc  <= 8'h00;
            sum  <= 8'h00;
            pusi <= 1'b0;
            nul  <= 1'b0;
        end else if (ts_valid && ts_ready) begin
            pos <= (pos == PKT_LAST) ? PKT_FIRST : pos + 8'h01;
            acc <= (pos == PKT_LAST) ? 8'h00 : acc ^ ts_byte;
            if (pos == PKT_LAST) sum <= acc ^ ts_byte;
            if (pos == HDR_B1) pusi <= ts_byte[PUSI_BIT];
            if (pos == HDR_B2) nul <= ts_byte == STUFF_BYTE;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge core_clk); endclocking
    default disable iff (!resetn);
    valid_drop_a: assert property ($fell(ts_valid) |-> $past(ts_ready))
        else $error("offer dropped");
    offer_held_a: assert property (ts_valid && !ts_ready |=> ts_valid)
        else $error("offer withdrawn");
    data_held_a: assert property (ts_valid && !ts_ready |=>
        $stable(ts_byte) && $stable(ts_chk)) else $error("stalled byte moved");
    sync_first_a: assert property (ts_valid && pos == PKT_FIRST
        |-> ts_byte == SYNC_BYTE) else $error("no sync byte");
    check_sum_a: assert property (ts_valid && pos == PKT_FIRST
        |-> ts_chk == sum) else $error("bad checksum");
    id_high_a: assert property (ts_valid && pos == HDR_B1
        |-> ts_byte[4:0] == 5'h1f && !ts_byte[TEI_BIT])
        else $error("bad header byte");
    id_low_a: assert property (ts_valid && pos == HDR_B2
        |-> ts_byte[7:1] == 7'h7f) else $error("bad packet id");
    no_adapt_a: assert property (ts_valid && pos == HDR_B3
        |-> ts_byte[AFC_HI:AFC_LO] == AFC_PAYLOAD)
        else $error("adaptation field used");
    null_fill_a: assert property (ts_valid && nul && pos > HDR_B3
        |-> ts_byte == STUFF_BYTE) else $error("null packet not fill");
    ptr_range_a: assert property (ts_valid && pusi && !nul && pos == PTR_POS
        |-> ts_byte < START_LAST) else $error("pointer past payload");
    stall_c: cover property (ts_valid && !ts_ready);
    ptr_c: cover property (ts_valid && pusi && !nul && pos == PTR_POS);
    null_c: cover property (ts_valid && nul && pos == PKT_LAST);
endmodule : dtcfd_link_asserts
`default_nettype wire

// ---- downstream_tc_mac_frame_delineator_test.sv ----
// Bench: headend into delineator, plus a hand-driven faulty feed
`timescale 1ns/10ps
`default_nettype none
module downstream_tc_mac_frame_delineator_test;
    import dtcfd_pkg::*;
    logic core_clk = 1'b0, resetn = 1'b0, u_valid = 1'b0, ry = 1'b0;
    logic [7:0] u_data = 8'h00, xs = 8'h00, pl [184];
    logic u_ready, tx_stamp, stamp_a, v_a, v_b, lk_a, lk_b;
    logic [10:0] w_a, w_b, qa [$], qb [$];
    int fail_count = 0, n_tests = 0, cyc = 0, ntx = 0, nrx = 0, fk, flen;
    dtcfd_link_if la ();
    dtcfd_link_if lb ();
    dtcfd_headend dtcfd_headend_inst (.core_clk(core_clk), .resetn(resetn),
        .link(la), .u_data(u_data), .u_valid(u_valid), .u_ready(u_ready),
        .tx_stamp(tx_stamp));
    dtcfd_delineator dtcfd_delineator_inst (.core_clk(core_clk),
        .resetn(resetn), .link(la), .rx_data(w_a[7:0]), .rx_sof(w_a[8]),
        .rx_eof(w_a[9]), .rx_abort(w_a[10]), .rx_valid(v_a), .rx_ready(ry),
        .rx_locked(lk_a), .rx_stamp(stamp_a));
    dtcfd_delineator dtcfd_delineator_inst_b (.core_clk(core_clk),
        .resetn(resetn), .link(lb), .rx_data(w_b[7:0]), .rx_sof(w_b[8]),
        .rx_eof(w_b[9]), .rx_abort(w_b[10]), .rx_valid(v_b), .rx_ready(ry),
        .rx_locked(lk_b), .rx_stamp());
    dtcfd_link_asserts dtcfd_link_asserts_inst (.core_clk(core_clk),
        .resetn(resetn), .ts_byte(la.ts_byte), .ts_chk(la.ts_chk),
        .ts_valid(la.ts_valid), .ts_ready(la.ts_ready));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk_w(input string s, input logic [10:0] e, g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask : chk_w
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test
    function automatic logic [7:0] fb(int k, logic [15:0] n, logic [7:0] c);
        if (k == 0) return c;
        if (k == 2) return n[15:8];
        if (k == 3) return n[7:0];
        return 8'(k * 7);
    endfunction : fb
    task automatic send_a(input logic [7:0] c, input logic [15:0] n);
        int t;
        t = (c == 8'hc4) ? 6 : int'(n) + 6;
        for (int k = 0; k < t; k++) begin
            u_data = fb(k, n, c);
            u_valid = 1'b1;
            qa.push_back({1'b0, k == t - 1, k == 0, u_data});
            do @(posedge core_clk); while (u_ready !== 1'b1);
            #1;
        end
    endtask : send_a
    task automatic put_b(input logic [7:0] b, input logic [7:0] c);
        lb.ts_byte = b;
        lb.ts_chk = c;
        lb.ts_valid = 1'b1;
        do @(posedge core_clk); while (lb.ts_ready !== 1'b1);
        #1;
    endtask : put_b
    // Bad corrupts only the checksum sent
    task automatic pkt(input logic [7:0] b1, input logic [7:0] b2,
                       input logic [3:0] cc, input logic bad);
        logic [7:0] x;
        x = 8'h47 ^ b1 ^ b2 ^ {4'h1, cc};
        put_b(8'h47, bad ? ~xs : xs);
        put_b(b1, ~b1);
        put_b(b2, ~b2);
        put_b({4'h1, cc}, 8'h5a);
        foreach (pl[i]) begin
            put_b(pl[i], ~pl[i]);
            x ^= pl[i];
        end
        xs = x;
    endtask : pkt
    task automatic put_fb(input int lo, hi);
        for (int i = lo; i < hi; i++) begin
            pl[i] = fb(fk, 16'(flen - 6), 8'h08);
            qb.push_back({1'b0, fk == flen - 1, fk == 0, pl[i]});
            fk++;
        end
    endtask : put_fb
    task automatic fill(input logic [7:0] v, input int n, input int ptr);
        foreach (pl[i]) pl[i] = v;
        pl[0] = 8'(ptr);
        flen = n;
        fk = 0;
    endtask : fill
    ////////////////////////////////////////////////////////////////////////
    initial forever #5 core_clk = ~core_clk;
    always @(posedge core_clk) #1 ry = ($urandom % 4) != 0;
    always @(posedge core_clk) begin
        cyc++;
        ntx += int'(tx_stamp === 1'b1);
        nrx += int'(stamp_a === 1'b1);
        if (v_a === 1'b1 && ry === 1'b1)
            chk_w("word a", qa.size() ? qa.pop_front() : 11'h7ff, w_a);
        if (v_b === 1'b1 && ry === 1'b1)
            chk_w("word b", qb.size() ? qb.pop_front() : 11'h7ff, w_b);
        if (cyc == 30000) begin
            fail_count++;
            stop_test();
        end
    end
    initial begin
        void'($urandom(17944));
        {lb.ts_byte, lb.ts_chk, lb.ts_valid} = 17'h0;
        repeat (3) @(posedge core_clk);
        #1 resetn = 1'b1;
        fork
            begin
                for (int t = 0; t < 3000 && lk_a !== 1'b1; t++)
                    @(posedge core_clk);
                #1 chk_w("lock a", 11'h1, 11'(lk_a));
                send_a(8'hc4, 16'h0123);
                for (int f = 0; f < 6; f++)
                    send_a(8'($urandom) & 8'h3e, 16'($urandom % 400));
                u_valid = 1'b0;
            end
            begin
                @(posedge core_clk);
                #1 fill(8'hff, 0, 255);
                for (int p = 0; p < 6; p++) begin
                    if (p == 5) chk_w("early lock", 11'h0, 11'(lk_b));
                    pkt(8'h3f, 8'hff, 4'(p), 1'b0);
                end
                chk_w("lock b", 11'h1, 11'(lk_b));
                fill(8'hff, 6, 2);
                pl[1] = 8'h11;
                put_fb(5, 11);
                flen = 206;
                fk = 0;
                put_fb(11, 184);
                pkt(8'h7f, 8'hfe, 4'h0, 1'b0);
                fill(8'hff, 206, 33);
                fk = 173;
                put_fb(1, 34);
                flen = 306;
                fk = 0;
                put_fb(40, 184);
                pkt(8'h7f, 8'hfe, 4'h1, 1'b0);
                fill(8'h22, 0, 34);
                qb.push_back(11'h400);
                pkt(8'h3f, 8'hfe, 4'h3, 1'b0);
                fill(8'hff, 306, 0);
                put_fb(1, 184);
                pkt(8'h7f, 8'hfe, 4'h4, 1'b0);
                fill(8'hff, 0, 255);
                for (int p = 0; p < 9; p++) begin
                    if (p == 8) chk_w("held", 11'h1, 11'(lk_b));
                    if (p == 8) qb.push_back(11'h400);
                    pkt(8'h3f, 8'hff, 4'(p), 1'b1);
                end
                chk_w("lock lost", 11'h0, 11'(lk_b));
                lb.ts_valid = 1'b0;
            end
        join
        for (int t = 0; t < 5000 && qa.size() + qb.size() > 0; t++)
            @(posedge core_clk);
        chk_w("drain", 11'h0, 11'(qa.size() + qb.size()));
        chk_w("tx stamps", 11'h7, 11'(ntx));
        chk_w("rx stamps", 11'h7, 11'(nrx));
        stop_test();
    end
endmodule : downstream_tc_mac_frame_delineator_test
`default_nettype wire
